// file: rtl/switch_pkg.sv
/*
 * Shared constants and types for the port forwarding core.
 * Assumes byte-wide frame streams whose first twelve bytes are the
 * destination and source station addresses.
 */
package switch_pkg;

    // ==========================================================
    // Frame layout
    localparam int         ADDR_BYTES = 6;
    localparam int         HDR_BYTES  = 12;
    localparam int         MCAST_BIT  = 0;
    localparam int         ADDR_W     = 48;

    // ==========================================================
    // Line patterns
    // Also a legal data byte; stations see a collision on tx_col, not on this pattern
    localparam logic [7:0] JAM_BYTE   = 8'haa;
    localparam logic [7:0] IDLE_BYTE  = 8'h00;

    // ==========================================================
    // Forwarding engine states
    typedef enum logic [1:0] {
        FWD_IDLE   = 2'b00,
        FWD_LOOKUP = 2'b01,
        FWD_COPY   = 2'b11
    } fwd_state_type;

endpackage

// file: rtl/frame_if.sv
/*
 * Handshake bundle between a one-frame queue and its user.
 * Assumes one writer and one reader, both on ref_clk.
 */
`timescale 1ns/100ps
interface frame_if import switch_pkg::*; ();
    logic                       wr_valid;
    logic                       wr_ready;
    logic                       wr_last;
    logic [7:0]                 wr_data;
    logic                       rd_valid;
    logic                       rd_ready;
    logic                       rd_last;
    logic [7:0]                 rd_data;
    logic                       short_frame;
    logic [HDR_BYTES-1:0][7:0]  head;

    modport queue_side (input wr_valid, wr_last, wr_data, rd_ready,
                        output wr_ready, rd_valid, rd_last, rd_data, short_frame, head);
    modport user_side  (output wr_valid, wr_last, wr_data, rd_ready,
                        input wr_ready, rd_valid, rd_last, rd_data, short_frame, head);
endinterface

// file: rtl/frame_queue.sv
/*
 * One-frame store: fills byte by byte, then drains the whole frame.
 * Assumes the writer marks the final byte with wr_last; bytes past
 * DEPTH are discarded, so over-long frames come out truncated.
 */
`timescale 1ns/100ps
module frame_queue import switch_pkg::*; #(
    parameter int DEPTH = 64
) (
    input  wire logic ref_clk,
    input  wire logic resetn,
    frame_if.queue_side q
);
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < HDR_BYTES) begin : g_check
        $error("frame_queue: DEPTH must hold the address header");
    end

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [CW-1:0]         count;
        logic [CW-1:0]         rd_ptr;
        logic                  done;
    } queue_state_type;

    queue_state_type st_reg;
    queue_state_type st_next;

    assign q.wr_ready    = !st_reg.done;
    assign q.rd_valid    = st_reg.done;
    assign q.rd_data     = st_reg.mem[st_reg.rd_ptr];
    assign q.rd_last     = (st_reg.rd_ptr == CW'(st_reg.count - 1'b1));
    assign q.short_frame = (st_reg.count < CW'(HDR_BYTES));
    assign q.head        = st_reg.mem[HDR_BYTES-1:0];

    // ==========================================================
    // Next state
    always_comb begin
        st_next = st_reg;
        if (q.wr_valid && !st_reg.done) begin
            if (st_reg.count < CW'(DEPTH)) begin
                st_next.mem[st_reg.count] = q.wr_data;
                st_next.count             = CW'(st_reg.count + 1'b1);
            end
            st_next.done = q.wr_last;
        end
        if (q.rd_ready && st_reg.done) begin
            if (q.rd_last) begin
                st_next.rd_ptr = '0;
                st_next.count  = '0;
                st_next.done   = 1'b0;
            end else begin
                st_next.rd_ptr = CW'(st_reg.rd_ptr + 1'b1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_store_count: assert property (
        (q.wr_valid && !st_reg.done && st_reg.count < CW'(DEPTH))
            |=> st_reg.count == CW'($past(st_reg.count) + 1'b1))
        else $error("queue byte not stored");

    a_hold_frame: assert property (
        (st_reg.done && !q.rd_ready) |=> st_reg.done && $stable(st_reg.count))
        else $error("stored frame lost without read");

endmodule

// file: rtl/ethernet_switch_forwarding.sv
/*
 * Multiport frame forwarding core: repeater mode or switching mode.
 * Assumes byte-wide streams per port, synchronous to ref_clk, whose
 * stations cannot be stalled except by a seen collision.
 */
`timescale 1ns/100ps
module ethernet_switch_forwarding import switch_pkg::*; #(
    parameter int N_PORTS   = 4,
    parameter int DEPTH     = 64,
    parameter int TABLE_LEN = 16
) (
    input  wire logic                    ref_clk,
    input  wire logic                    resetn,
    input  wire logic                    switch_mode,
    input  wire logic                    bp_enable,
    input  wire logic [N_PORTS-1:0]      full_duplex,
    input  wire logic [N_PORTS-1:0]      rx_valid,
    input  wire logic [N_PORTS-1:0]      rx_last,
    input  wire logic [N_PORTS-1:0][7:0] rx_data,
    output logic      [N_PORTS-1:0]      tx_valid,
    output logic      [N_PORTS-1:0]      tx_last,
    output logic      [N_PORTS-1:0]      tx_col,
    output logic      [N_PORTS-1:0][7:0] tx_data
);
    localparam int PW = $clog2(N_PORTS);
    localparam int TW = $clog2(TABLE_LEN);

    if (N_PORTS < 2 || TABLE_LEN < 2 || (TABLE_LEN & (TABLE_LEN - 1)) != 0) begin : g_check
        $error("ethernet_switch_forwarding: unsupported port count or table size");
    end

    typedef struct packed {
        logic [N_PORTS-1:0]                 tx_valid;
        logic [N_PORTS-1:0]                 tx_last;
        logic [N_PORTS-1:0]                 tx_col;
        logic [N_PORTS-1:0][7:0]            tx_data;
        logic [N_PORTS-1:0]                 rx_busy;
        logic [N_PORTS-1:0]                 reject;
        fwd_state_type                      fwd;
        logic [PW-1:0]                      src;
        logic [PW-1:0]                      rr;
        logic [N_PORTS-1:0]                 mask;
        logic [TABLE_LEN-1:0]               tab_valid;
        logic [TABLE_LEN-1:0][ADDR_W-1:0]   tab_addr;
        logic [TABLE_LEN-1:0][PW-1:0]       tab_port;
        logic [TW-1:0]                      tab_next;
    } state_type;

    state_type st_reg;
    state_type st_next;

    logic [N_PORTS-1:0]                        iq_wr_valid;
    logic [N_PORTS-1:0]                        iq_wr_ready;
    logic [N_PORTS-1:0]                        iq_rd_valid;
    logic [N_PORTS-1:0]                        iq_rd_ready;
    logic [N_PORTS-1:0]                        iq_rd_last;
    logic [N_PORTS-1:0][7:0]                   iq_rd_data;
    logic [N_PORTS-1:0]                        iq_short;
    logic [N_PORTS-1:0][HDR_BYTES-1:0][7:0]    iq_head;
    logic [N_PORTS-1:0]                        oq_wr_valid;
    logic [N_PORTS-1:0]                        oq_wr_ready;
    logic                                      oq_wr_last;
    logic [7:0]                                oq_wr_data;
    logic [N_PORTS-1:0]                        oq_rd_valid;
    logic [N_PORTS-1:0]                        oq_rd_ready;
    logic [N_PORTS-1:0]                        oq_rd_last;
    logic [N_PORTS-1:0][7:0]                   oq_rd_data;
    logic                                      lk_mc;
    logic                                      lk_ready;
    logic [N_PORTS-1:0]                        lk_others;

    // ==========================================================
    // Per-port queues
    for (genvar p = 0; p < N_PORTS; p++) begin : g_port
        frame_if in_q ();
        frame_if out_q ();

        frame_queue #(.DEPTH(DEPTH)) u_in  (.ref_clk(ref_clk), .resetn(resetn), .q(in_q));
        frame_queue #(.DEPTH(DEPTH)) u_out (.ref_clk(ref_clk), .resetn(resetn), .q(out_q));

        assign in_q.wr_valid  = iq_wr_valid[p];
        assign in_q.wr_last   = rx_last[p];
        assign in_q.wr_data   = rx_data[p];
        assign in_q.rd_ready  = iq_rd_ready[p];
        assign iq_wr_ready[p] = in_q.wr_ready;
        assign iq_rd_valid[p] = in_q.rd_valid;
        assign iq_rd_last[p]  = in_q.rd_last;
        assign iq_rd_data[p]  = in_q.rd_data;
        assign iq_short[p]    = in_q.short_frame;
        assign iq_head[p]     = in_q.head;

        assign out_q.wr_valid = oq_wr_valid[p];
        assign out_q.wr_last  = oq_wr_last;
        assign out_q.wr_data  = oq_wr_data;
        assign out_q.rd_ready = oq_rd_ready[p];
        assign oq_wr_ready[p] = out_q.wr_ready;
        assign oq_rd_valid[p] = out_q.rd_valid;
        assign oq_rd_last[p]  = out_q.rd_last;
        assign oq_rd_data[p]  = out_q.rd_data;
    end

    // ==========================================================
    // Next state
    always_comb begin
        logic [ADDR_W-1:0]  dst;
        logic [ADDR_W-1:0]  sa;
        logic [N_PORTS-1:0] want;
        logic [PW-1:0]      cand;
        logic [PW-1:0]      hit_port;
        logic               hit;
        logic               seen;
        logic               rej;
        logic [7:0]         rep_byte;
        logic               rep_last;
        dst      = '0;
        sa       = '0;
        want     = '0;
        cand     = '0;
        hit_port = '0;
        hit      = 1'b0;
        seen     = 1'b0;
        rej      = 1'b0;
        rep_byte = IDLE_BYTE;
        rep_last = 1'b0;
        st_next  = st_reg;
        iq_wr_valid = '0;
        iq_rd_ready = '0;
        oq_wr_valid = '0;
        oq_wr_last  = 1'b0;
        oq_wr_data  = IDLE_BYTE;
        oq_rd_ready = '0;
        st_next.tx_valid = '0;
        st_next.tx_last  = '0;
        st_next.tx_col   = '0;
        st_next.tx_data  = '0;

        if (!switch_mode) begin
            // Stations neither fill nor drain the queues while repeating; a frame already in the engine still completes
            for (int p = 0; p < N_PORTS; p++) begin
                if (rx_valid[p]) begin
                    rep_byte = rx_data[p];
                    rep_last = rx_last[p];
                end
            end
            if (!$onehot0(rx_valid)) begin
                st_next.tx_valid = '1;
                st_next.tx_col   = '1;
                st_next.tx_data  = {N_PORTS{JAM_BYTE}};
            end else if (|rx_valid) begin
                st_next.tx_valid = '1;
                st_next.tx_last  = {N_PORTS{rep_last}};
                st_next.tx_data  = {N_PORTS{rep_byte}};
            end
        end else begin
            for (int p = 0; p < N_PORTS; p++) begin
                if (rx_valid[p]) begin
                    rej = st_reg.rx_busy[p] ? st_reg.reject[p] : !iq_wr_ready[p];
                    st_next.reject[p]  = rej && !rx_last[p];
                    st_next.rx_busy[p] = !rx_last[p];
                    iq_wr_valid[p]     = !rej;
                    if (rej && bp_enable && !full_duplex[p]) begin
                        st_next.tx_valid[p] = 1'b1;
                        st_next.tx_col[p]   = 1'b1;
                        st_next.tx_data[p]  = JAM_BYTE;
                    end else if (!full_duplex[p]) begin
                        st_next.tx_valid[p] = 1'b1;
                        st_next.tx_last[p]  = rx_last[p];
                        st_next.tx_data[p]  = rx_data[p];
                    end
                end
                // Half-duplex egress waits for a silent station; full duplex never does
                oq_rd_ready[p] = full_duplex[p] || !(rx_valid[p] || st_reg.rx_busy[p]);
                if (oq_rd_ready[p] && oq_rd_valid[p]) begin
                    st_next.tx_valid[p] = 1'b1;
                    st_next.tx_last[p]  = oq_rd_last[p];
                    st_next.tx_data[p]  = oq_rd_data[p];
                end
            end
        end

        // Forwarding engine, one frame at a time
        for (int b = 0; b < ADDR_BYTES; b++) begin
            dst[ADDR_W-1-8*b -: 8] = iq_head[st_reg.src][b];
            sa[ADDR_W-1-8*b -: 8]  = iq_head[st_reg.src][ADDR_BYTES+b];
        end
        lk_mc     = iq_head[st_reg.src][0][MCAST_BIT];
        lk_others = ~(N_PORTS'(1) << st_reg.src);
        for (int t = 0; t < TABLE_LEN; t++) begin
            if (st_reg.tab_valid[t] && st_reg.tab_addr[t] == dst) begin
                hit      = 1'b1;
                hit_port = st_reg.tab_port[t];
            end
        end
        if (iq_short[st_reg.src]) begin
            want = '0;
        end else if (hit && !lk_mc) begin
            want = N_PORTS'(1) << hit_port;
        end else begin
            want = lk_others;
        end
        want     = want & lk_others;
        lk_ready = &(oq_wr_ready | ~want);

        unique case (st_reg.fwd)
            FWD_IDLE: begin
                if (switch_mode) begin
                    for (int i = 0; i < N_PORTS; i++) begin
                        cand = PW'((int'(st_reg.rr) + 1 + i) % N_PORTS);
                        if (!seen && iq_rd_valid[cand]) begin
                            seen           = 1'b1;
                            st_next.src    = cand;
                            st_next.rr     = cand;
                            st_next.fwd    = FWD_LOOKUP;
                        end
                    end
                end
            end
            FWD_LOOKUP: begin
                if (!iq_short[st_reg.src]) begin
                    for (int t = 0; t < TABLE_LEN; t++) begin
                        if (st_reg.tab_valid[t] && st_reg.tab_addr[t] == sa) begin
                            seen                = 1'b1;
                            st_next.tab_port[t] = st_reg.src;
                        end
                    end
                    if (!seen) begin
                        st_next.tab_valid[st_reg.tab_next] = 1'b1;
                        st_next.tab_addr[st_reg.tab_next]  = sa;
                        st_next.tab_port[st_reg.tab_next]  = st_reg.src;
                        st_next.tab_next = TW'(st_reg.tab_next + 1'b1);
                    end
                end
                if (lk_ready) begin
                    st_next.mask = want;
                    st_next.fwd  = FWD_COPY;
                end
            end
            FWD_COPY: begin
                iq_rd_ready[st_reg.src] = 1'b1;
                oq_wr_data = iq_rd_data[st_reg.src];
                oq_wr_last = iq_rd_last[st_reg.src];
                if (iq_rd_valid[st_reg.src]) begin
                    oq_wr_valid = st_reg.mask;
                    if (iq_rd_last[st_reg.src]) begin
                        st_next.fwd = FWD_IDLE;
                    end
                end
            end
            default: begin
                st_next.fwd = FWD_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tx_valid = st_reg.tx_valid;
    assign tx_last  = st_reg.tx_last;
    assign tx_col   = st_reg.tx_col;
    assign tx_data  = st_reg.tx_data;

    // ==========================================================
    // Checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_copy_end;
        st_reg.fwd == FWD_COPY && iq_rd_valid[st_reg.src] && iq_rd_last[st_reg.src];
    endsequence

    a_repeat_copy: assert property (
        (!switch_mode && $onehot(rx_valid)) |=> (&tx_valid && tx_col == '0))
        else $error("repeated byte missing on a port");

    a_collide_jam: assert property (
        (!switch_mode && !$onehot0(rx_valid))
            |=> (&tx_col && tx_data == {N_PORTS{JAM_BYTE}}))
        else $error("collision not jammed on all ports");

    a_fd_no_col: assert property (
        switch_mode |=> (tx_col & $past(full_duplex)) == '0)
        else $error("collision shown to full-duplex port");

    a_bp_gated: assert property (
        (switch_mode && !bp_enable) |=> tx_col == '0)
        else $error("jam sent with back pressure off");

    a_flood_mc: assert property (
        (st_reg.fwd == FWD_LOOKUP && lk_mc && lk_ready && !iq_short[st_reg.src])
            |=> st_reg.mask == $past(lk_others))
        else $error("multicast not flooded");

    a_copy_mask: assert property (
        (oq_wr_valid != '0)
            |-> (st_reg.fwd == FWD_COPY && oq_wr_valid == st_reg.mask
                 && !oq_wr_valid[st_reg.src]))
        else $error("frame copied to wrong ports");

    a_lookup_go: assert property (
        (st_reg.fwd == FWD_LOOKUP && lk_ready) |=> st_reg.fwd == FWD_COPY)
        else $error("lookup did not start copy");

    a_serial_end: assert property (
        s_copy_end |=> st_reg.fwd == FWD_IDLE ##1 st_reg.fwd != FWD_COPY)
        else $error("frames to egress overlapped");

    for (genvar p = 0; p < N_PORTS; p++) begin : g_chk
        a_echo_half: assert property (
            (switch_mode && rx_valid[p] && !full_duplex[p])
                |=> (tx_valid[p] && (tx_col[p] || tx_data[p] == $past(rx_data[p]))))
            else $error("half-duplex echo missing");
    end

endmodule

// file: sim/eth_station.sv
/*
 * Behavioural station for one port of the forwarding core.
 * Assumes byte timing on ref_clk; the bench calls send() per frame.
 */
`timescale 1ns/100ps
module eth_station (
    input  wire logic       ref_clk,
    input  wire logic       full_duplex,
    input  wire logic       tx_valid,
    input  wire logic       tx_col,
    output logic            rx_valid,
    output logic            rx_last,
    output logic [7:0]      rx_data
);
    logic [7:0] backoff_reg;

    initial begin
        rx_valid    = 1'b0;
        rx_last     = 1'b0;
        rx_data     = 8'h00;
        backoff_reg = 8'h5a;
    end

    task automatic send(input logic [7:0] f[$]);
        int tries;
        int i;
        int w;
        bit hit;
        tries = 0;
        hit   = 1'b1;
        while (hit && tries < 8) begin
            hit = 1'b0;
            tries++;
            // Carrier sense on half duplex only
            for (w = 0; w < 200 && tx_valid && !full_duplex; w++) begin
                @(posedge ref_clk);
            end
            for (i = 0; i < f.size() && !hit; i++) begin
                rx_valid <= 1'b1;
                rx_last  <= (i == f.size() - 1);
                rx_data  <= f[i];
                @(posedge ref_clk);
                hit = tx_col && !full_duplex && (i < f.size() - 1);
            end
            if (hit) begin
                // Close the aborted frame so the hub can find the next start
                rx_last <= 1'b1;
                rx_data <= 8'haa;
                @(posedge ref_clk);
            end
            rx_valid    <= 1'b0;
            rx_last     <= 1'b0;
            rx_data     <= ~rx_data;
            backoff_reg <= {backoff_reg[6:0], backoff_reg[7] ^ backoff_reg[5]} ^ f[f.size()-1];
            @(posedge ref_clk);
            if (hit) begin
                repeat (1 + backoff_reg[3:0]) @(posedge ref_clk);
            end
        end
    endtask
endmodule

// file: sim/ethernet_switch_forwarding_tb.sv
/*
 * Self-checking bench for the forwarding core with four stations.
 * Assumes the core's one-frame queues; stimulus from a fixed LFSR.
 */
`timescale 1ns/100ps
module ethernet_switch_forwarding_tb;
    import switch_pkg::*;
    localparam logic [47:0] ADDR_A = 48'h020000000a0a;
    localparam logic [47:0] ADDR_B = 48'h020000000b0b;
    localparam logic [47:0] ADDR_C = 48'h020000000c0c;
    localparam logic [47:0] ADDR_D = 48'h020000000d0d;
    localparam logic [47:0] ADDR_U = 48'h040000000077;

    logic             ref_clk = 1'b0;
    logic             resetn = 1'b0;
    logic             switch_mode = 1'b0;
    logic             bp_enable = 1'b0;
    logic [3:0]       full_duplex = 4'h0;
    logic [3:0]       rx_valid;
    logic [3:0]       rx_last;
    logic [3:0][7:0]  rx_data;
    logic [3:0]       tx_valid;
    logic [3:0]       tx_last;
    logic [3:0]       tx_col;
    logic [3:0][7:0]  tx_data;
    logic [7:0]       got [4][$];
    logic [7:0]       fa[$];
    logic [7:0]       fb[$];
    logic [7:0]       cat[$];
    logic [7:0]       none[$];
    int               nfr [4];
    int               ncol [4];
    int               n_fail = 0;
    int               checks_done = 0;
    logic [15:0]      seed = 16'h002e;

    always #20 ref_clk = ~ref_clk;

    ethernet_switch_forwarding #(.N_PORTS(4), .DEPTH(16), .TABLE_LEN(4)) i_dut (
        .ref_clk     (ref_clk),
        .resetn      (resetn),
        .switch_mode (switch_mode),
        .bp_enable   (bp_enable),
        .full_duplex (full_duplex),
        .rx_valid    (rx_valid),
        .rx_last     (rx_last),
        .rx_data     (rx_data),
        .tx_valid    (tx_valid),
        .tx_last     (tx_last),
        .tx_col      (tx_col),
        .tx_data     (tx_data)
    );

    eth_station st[3:0] (
        .ref_clk     (ref_clk),
        .full_duplex (full_duplex),
        .tx_valid    (tx_valid),
        .tx_col      (tx_col),
        .rx_valid    (rx_valid),
        .rx_last     (rx_last),
        .rx_data     (rx_data)
    );

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    function automatic logic [31:0] fsum(input logic [7:0] f[$]);
        logic [31:0] s;
        s = 32'h0;
        foreach (f[i]) s = {s[30:0], s[31]} ^ {24'h0, f[i]};
        return s;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expd);
        checks_done++;
        if (seen !== expd) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, expd, seen);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ==========================================================
    // Line monitor; jam bytes counted only with the jam pattern
    always @(posedge ref_clk) begin
        for (int p = 0; p < 4; p++) begin
            if (tx_valid[p] === 1'b1 && tx_col[p] !== 1'b1) got[p].push_back(tx_data[p]);
            if (tx_last[p] === 1'b1) nfr[p]++;
            if (tx_col[p] === 1'b1 && tx_data[p] === JAM_BYTE) ncol[p]++;
            if (full_duplex[p] && resetn) check("full duplex jam", tx_col[p], 1'b0);
        end
    end

    task automatic build(output logic [7:0] f[$], input logic [47:0] dst, input logic [47:0] src);
        int n;
        f = {};
        seed = lfsr(seed);
        n = 12 + seed[1:0] + seed[2];
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            if (i < 6) f.push_back(dst[47-8*i -: 8]);
            else if (i < 12) f.push_back(src[95-8*i -: 8]);
            else f.push_back(seed[7:0]);
        end
    endtask

    task automatic send_on(input int p, input logic [7:0] f[$]);
        case (p)
            0: st[0].send(f);
            1: st[1].send(f);
            2: st[2].send(f);
            default: st[3].send(f);
        endcase
    endtask

    task automatic clear();
        foreach (got[p]) got[p] = {};
        nfr  = '{default: 0};
        ncol = '{default: 0};
    endtask

    // Waits for 40 quiet cycles; a hang counts as a mismatch
    task automatic settle(input string nm);
        int n;
        int q;
        q = 0;
        for (n = 0; n < 3000 && q < 40; n++) begin
            @(posedge ref_clk);
            q = (tx_valid === 4'h0 && rx_valid === 4'h0) ? q + 1 : 0;
        end
        if (q < 40) begin
            n_fail++;
            give_verdict();
        end
        $display("test %s done", nm);
    endtask

    task automatic check_q(input int p, input logic [7:0] e[$]);
        check($sformatf("port%0d bytes", p), fsum(got[p]), fsum(e));
        check($sformatf("port%0d count", p), got[p].size(), e.size());
    endtask

    task automatic twice_from_1(input string nm);
        clear();
        build(fa, ADDR_A, ADDR_C);
        build(fb, ADDR_A, ADDR_C);
        send_on(1, fa);
        send_on(1, fb);
        settle(nm);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        clear();
        build(fa, ADDR_B, ADDR_A);
        send_on(seed[1:0], fa);
        settle("repeat");
        for (int i = 0; i < 4; i++) check_q(i, fa);
        clear();
        build(fa, ADDR_B, ADDR_A);
        build(fb, ADDR_A, ADDR_B);
        fork
            send_on(0, fa);
            send_on(2, fb);
        join
        settle("repeat collision");
        for (int i = 0; i < 4; i++) check("jam seen", ncol[i] != 0, 1'b1);
        switch_mode <= 1'b1;
        @(posedge ref_clk);
        clear();
        build(fa, ADDR_U, ADDR_A);
        send_on(0, fa);
        settle("flood unknown");
        check_q(0, fa);
        for (int i = 1; i < 4; i++) check_q(i, fa);
        clear();
        build(fa, ADDR_A, ADDR_B);
        send_on(2, fa);
        settle("learned unicast");
        check_q(0, fa);
        check_q(1, none);
        check_q(3, none);
        foreach (cat[i]) cat[i] = 8'h00;
        for (int k = 0; k < 2; k++) begin
            clear();
            build(fa, k ? 48'hffffffffffff : 48'h030000000055, ADDR_C);
            send_on(1, fa);
            settle("group");
            check_q(0, fa);
            check_q(2, fa);
            check_q(3, fa);
        end
        clear();
        build(fa, ADDR_A, ADDR_C);
        build(fb, ADDR_A, ADDR_D);
        fork
            send_on(1, fa);
            send_on(3, fb);
        join
        settle("same egress");
        check("frames on port0", nfr[0], 2);
        cat = {fa, fb};
        if (fsum(got[0]) !== fsum(cat)) cat = {fb, fa};
        check_q(0, cat);
        twice_from_1("drop");
        check("frames kept", nfr[0], 1);
        check("no jam when dropping", ncol[1], 0);
        bp_enable <= 1'b1;
        twice_from_1("back pressure");
        check("jam toward sender", ncol[1] != 0, 1'b1);
        full_duplex <= 4'b0010;
        twice_from_1("full duplex");
        check("no jam on full duplex", ncol[1], 0);
        check_q(1, none);
        give_verdict();
    end
endmodule
